//--- design/oledh_pkg.sv
// Purpose: shared constants and types of the display host port pair
// Assumes: one 10 MHz clock on both ends, pins cross as foreign inputs
// Notes: pin bundle packs every device input into one word
package oledh_pkg;

  // pin bundle layout seen by the device end
  localparam int PIN_W = 16;
  localparam int PIN_RD = 8;
  localparam int PIN_WR = 9;
  localparam int PIN_DC = 10;
  localparam int PIN_CS = 11;
  localparam int PIN_BUS = 12;
  localparam int PIN_CPU = 13;
  localparam int PIN_MRST = 14;
  localparam int PIN_HV = 15;
  // idle levels: select, write and read strobes high, all else low
  localparam logic [PIN_W-1:0] PIN_IDLE = 16'h0b00;

  // serial use of the data bus
  localparam int SER_CLK = 0;
  localparam int SER_IN = 1;
  localparam int SER_OUT = 2;
  localparam int SER_DIR = 3;
  localparam logic [7:0] SER_HOST_OE = 8'hfb;
  localparam logic [7:0] SER_DEV_OE = 8'h04;
  localparam logic [7:0] BUS_ALL = 8'hff;
  localparam logic [7:0] BUS_NONE = 8'h00;

  // two-entry write buffer
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  // host pin phase timing
  localparam int CLK_NS = 100;
  localparam int PHASE_NS = 1600;
  localparam logic [4:0] PHASE_CYC = 5'((PHASE_NS + CLK_NS - 1) / CLK_NS);

  // host register map (byte addresses) and fields
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_CMD = 12'h004;
  localparam logic [11:0] REG_STAT = 12'h008;
  localparam int CTRL_CPU = 0;
  localparam int CTRL_BUS = 1;
  localparam int CTRL_HV = 2;
  localparam int CTRL_MRST = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam int CMD_DC = 8;
  localparam int CMD_RD = 9;
  localparam int ST_BUSY = 0;
  localparam int ST_DEVBUSY = 1;
  localparam int ST_RDATA = 8;

  // device end state
  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] s3;
    logic [PIN_W-1:0] f;
    logic [7:0] shIn;
    logic [7:0] shOut;
    logic [7:0] dOut;
    logic [7:0] dOe;
    logic [2:0] bitCnt;
    logic [8:0] buf0;
    logic [8:0] buf1;
    logic [1:0] cnt;
    logic hv;
    logic init;
  } oledh_dev_t;

  localparam oledh_dev_t DEV_RESET = '{s1: PIN_IDLE, s2: PIN_IDLE,
    s3: PIN_IDLE, f: PIN_IDLE, init: 1'b1, default: '0};

endpackage : oledh_pkg

//--- design/oledh_if.sv
// Purpose: pin bundle between the display module and its host
// Assumes: unused bus bits float high through a pull-up
// Notes: the shared data wire is resolved here from both enables
`timescale 1ns/1ns
interface oledh_if;
  logic cpuSel;
  logic busSel;
  logic csN;
  logic moduleResetN;
  logic dcSel;
  logic wrN;
  logic rdN;
  logic panelSupplyOn;
  logic [7:0] hostOut;
  logic [7:0] hostOe;
  logic [7:0] devOut;
  logic [7:0] devOe;
  logic devBusy;
  logic panelVcc;
  logic [7:0] busLevel;

  // per-bit wired level, pull-up where nobody drives
  assign busLevel = (hostOe & hostOut) | (devOe & devOut) |
    ~(hostOe | devOe);

  modport dev (input cpuSel, busSel, csN, moduleResetN, dcSel, wrN, rdN,
    panelSupplyOn, busLevel, output devOut, devOe, devBusy, panelVcc);
  modport host (output cpuSel, busSel, csN, moduleResetN, dcSel, wrN, rdN,
    panelSupplyOn, hostOut, hostOe, input busLevel, devBusy, panelVcc);
endinterface : oledh_if

//--- design/oledh_dev.sv
// Purpose: display module end of the host port (80xx, 68xx, serial)
// Assumes: every pin is foreign and passes a three-stage filter
// Notes: writes land in a two-entry buffer; devBusy warns the host
`timescale 1ns/1ns
module oledh_dev
  import oledh_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pins toward the host
  oledh_if.dev bus,
  // received bytes
  output logic rxValid,
  input wire logic rxReady,
  output logic [7:0] rxData,
  output logic rxIsData,
  // byte returned on host reads
  input wire logic [7:0] txByte,
  // module status
  output logic initActive,
  output logic panelHvOn
);

  oledh_dev_t q;
  oledh_dev_t d;
  logic [PIN_W-1:0] pinsNow;
  logic [PIN_W-1:0] agree;
  logic [PIN_W-1:0] nw;
  logic [PIN_W-1:0] old;
  logic sel;
  logic push;
  logic [8:0] pushVal;
  logic [1:0] c;
  logic wrRise;
  logic rdFall;
  logic rdRise;
  logic ckRise;
  logic ckFall;

  // all device inputs gathered into one word
  assign pinsNow = {bus.panelSupplyOn, bus.moduleResetN, bus.cpuSel,
    bus.busSel, bus.csN, bus.dcSel, bus.wrN, bus.rdN, bus.busLevel};

  // next state of the whole end
  always_comb
  begin
    d = q;
    push = 1'b0;
    pushVal = '0;
    // three stages; a bit changes once stages two and three agree
    d.s1 = pinsNow;
    d.s2 = q.s1;
    d.s3 = q.s2;
    agree = ~(q.s2 ^ q.s3);
    d.f = (q.s2 & agree) | (q.f & ~agree);
    nw = d.f;
    old = q.f;
    sel = ~nw[PIN_CS];
    wrRise = ~old[PIN_WR] & nw[PIN_WR];
    rdFall = old[PIN_RD] & ~nw[PIN_RD];
    rdRise = ~old[PIN_RD] & nw[PIN_RD];
    ckRise = ~old[SER_CLK] & nw[SER_CLK];
    ckFall = old[SER_CLK] & ~nw[SER_CLK];
    d.dOe = BUS_NONE;
    if (!nw[PIN_BUS])
    begin
      // serial: byte shifts msb first; read byte reloads per byte
      if (!sel)
      begin
        d.bitCnt = '0;
        d.shOut = txByte;
      end
      else if (ckRise && !nw[SER_DIR])
      begin
        d.shIn = {q.shIn[6:0], nw[SER_IN]};
        d.bitCnt = q.bitCnt + 3'h1;
        if (q.bitCnt == 3'h7)
        begin
          push = 1'b1;
          pushVal = {nw[PIN_DC], d.shIn};
        end
      end
      else if (ckFall && nw[SER_DIR])
      begin
        d.shOut = {q.shOut[6:0], 1'b0};
        d.bitCnt = q.bitCnt + 3'h1;
        if (q.bitCnt == 3'h7)
        begin
          d.shOut = txByte;
        end
      end
      // only the serial out bit is driven, and only for reads
      d.dOut = d.shOut[7] ? SER_DEV_OE : BUS_NONE;
      if (sel && nw[SER_DIR])
      begin
        d.dOe = SER_DEV_OE;
      end
    end
    else if (!nw[PIN_CPU])
    begin
      // 80xx: separate strobes, byte taken as the write strobe rises
      if (sel && wrRise)
      begin
        push = 1'b1;
        pushVal = {nw[PIN_DC], nw[7:0]};
      end
      if (sel && rdFall)
      begin
        d.dOut = txByte;
      end
      if (sel && !nw[PIN_RD])
      begin
        d.dOe = BUS_ALL;
      end
    end
    else
    begin
      // 68xx: enable high starts the cycle, direction picks read/write
      // write data is taken as enable falls, when it has settled
      if (sel && rdRise && nw[PIN_WR])
      begin
        d.dOut = txByte;
      end
      if (sel && rdFall && !nw[PIN_WR])
      begin
        push = 1'b1;
        pushVal = {nw[PIN_DC], nw[7:0]};
      end
      if (sel && nw[PIN_RD] && nw[PIN_WR])
      begin
        d.dOe = BUS_ALL;
      end
    end
    // two-entry buffer: pop first so a full buffer can refill at once
    c = q.cnt;
    if (rxReady && q.cnt != 2'h0)
    begin
      d.buf0 = q.buf1;
      c = q.cnt - 2'h1;
    end
    // a byte meeting a full buffer is dropped; devBusy warns of this
    if (push && c != BUF_DEPTH)
    begin
      if (c == 2'h0)
      begin
        d.buf0 = pushVal;
      end
      else
      begin
        d.buf1 = pushVal;
      end
      c = c + 2'h1;
    end
    // count kept in flip-flops; rxValid follows it combinationally
    d.cnt = c;
    // module reset clears the port and the buffer until released
    d.init = ~nw[PIN_MRST];
    if (!nw[PIN_MRST])
    begin
      d.cnt = '0;
      d.bitCnt = '0;
      d.dOe = BUS_NONE;
    end
    d.hv = nw[PIN_HV];
  end

  // single state register, synchronous reset
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      q <= DEV_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  // outputs straight from the state
  assign rxValid = q.cnt != 2'h0;
  assign rxData = q.buf0[7:0];
  assign rxIsData = q.buf0[8];
  assign initActive = q.init;
  assign panelHvOn = q.hv;
  assign bus.panelVcc = q.hv;
  assign bus.devOut = q.dOut;
  assign bus.devOe = q.dOe;
  // full flag from the registered count, so the pin never glitches
  assign bus.devBusy = q.cnt == BUF_DEPTH;

endmodule : oledh_dev

//--- design/oledh_host.sv
// Purpose: host end driving the display module pins from APB orders
// Assumes: one transfer at a time; each pin phase lasts PHASE_CYC clocks
// Notes: phases are long because the far end filters every pin
`timescale 1ns/1ns
module oledh_host
  import oledh_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins toward the module
  oledh_if.host bus
);

  typedef enum logic [2:0] {
    IDLE = 3'b000, WAIT = 3'b001, SETUP = 3'b010, STROBE = 3'b011,
    HOLD = 3'b100, SERLO = 3'b101, SERHI = 3'b110, GAP = 3'b111
  } oledh_st_t;

  typedef struct packed {
    logic [3:0] ctrl;
    oledh_st_t st;
    logic [4:0] cnt;
    logic [2:0] bitCnt;
    logic [7:0] sh;
    logic dc;
    logic rd;
    logic [7:0] rdByte;
    logic [8:0] s1;
    logic [8:0] s2;
    logic [8:0] s3;
    logic [8:0] f;
    logic csN;
    logic wrN;
    logic rdN;
    logic [7:0] out;
    logic [7:0] oe;
    logic [31:0] prdata;
  } oledh_host_t;

  localparam oledh_host_t HOST_RESET = '{ctrl: CTRL_RESET, st: IDLE,
    csN: 1'b1, wrN: 1'b1, rdN: 1'b1, default: '0};

  oledh_host_t q;
  oledh_host_t d;
  logic [8:0] agree;
  logic access;
  logic mapped;
  logic busy;
  logic par;
  logic m68;
  logic phaseEnd;

  assign access = psel & penable;
  assign mapped = paddr == REG_CTRL || paddr == REG_CMD ||
    paddr == REG_STAT;
  assign busy = q.st != IDLE;
  assign par = q.ctrl[CTRL_BUS];
  assign m68 = q.ctrl[CTRL_CPU];
  assign phaseEnd = q.cnt == 5'h0;

  // next state: register file, pin filter and transfer sequencer
  always_comb
  begin
    d = q;
    // module inputs are foreign and filtered like the far end does
    d.s1 = {bus.devBusy, bus.busLevel};
    d.s2 = q.s1;
    d.s3 = q.s2;
    agree = ~(q.s2 ^ q.s3);
    d.f = (q.s2 & agree) | (q.f & ~agree);
    // read data is prepared in the setup cycle, valid in the access
    if (psel && !penable)
    begin
      unique case (paddr)
        REG_CTRL: d.prdata = {28'h0000000, q.ctrl};
        REG_STAT: d.prdata = {16'h0000, q.rdByte, 6'h00, q.f[8], busy};
        default: d.prdata = '0;
      endcase
    end
    if (!phaseEnd)
    begin
      d.cnt = q.cnt - 5'h1;
    end
    unique case (q.st)
      IDLE:
      begin
        // idle levels follow the selected family and bus type
        d.csN = 1'b1;
        d.wrN = 1'b1;
        d.rdN = ~m68;
        d.out = BUS_NONE;
        d.oe = par ? BUS_NONE : SER_HOST_OE;
        if (access && pwrite && paddr == REG_CTRL)
        begin
          d.ctrl = pwdata[3:0];
        end
        if (access && pwrite && paddr == REG_CMD)
        begin
          d.sh = pwdata[7:0];
          d.dc = pwdata[CMD_DC];
          d.rd = pwdata[CMD_RD];
          d.st = WAIT;
        end
      end
      WAIT:
      begin
        // a write waits while the far buffer is full
        if (q.rd || !q.f[8])
        begin
          d.st = SETUP;
          d.cnt = PHASE_CYC - 5'h1;
          d.csN = 1'b0;
          if (par)
          begin
            d.out = q.sh;
            d.oe = q.rd ? BUS_NONE : BUS_ALL;
            d.wrN = m68 ? q.rd : 1'b1;
          end
          else
          begin
            d.out = BUS_NONE;
            d.out[SER_DIR] = q.rd;
          end
        end
      end
      SETUP:
      begin
        if (phaseEnd)
        begin
          d.cnt = PHASE_CYC - 5'h1;
          d.bitCnt = '0;
          d.st = par ? STROBE : SERLO;
          if (!par)
          begin
            d.out[SER_IN] = q.sh[7];
          end
          else if (m68)
          begin
            d.rdN = 1'b1;
          end
          else if (q.rd)
          begin
            d.rdN = 1'b0;
          end
          else
          begin
            d.wrN = 1'b0;
          end
        end
      end
      STROBE:
      begin
        if (phaseEnd)
        begin
          d.cnt = PHASE_CYC - 5'h1;
          d.st = HOLD;
          d.rdN = ~m68;
          d.wrN = m68 ? q.wrN : 1'b1;
          if (q.rd)
          begin
            d.rdByte = q.f[7:0];
          end
        end
      end
      SERLO:
      begin
        if (phaseEnd)
        begin
          d.cnt = PHASE_CYC - 5'h1;
          d.st = SERHI;
          d.out[SER_CLK] = 1'b1;
        end
      end
      SERHI:
      begin
        // sample the module's bit just before the falling clock
        if (phaseEnd)
        begin
          d.cnt = PHASE_CYC - 5'h1;
          d.sh = {q.sh[6:0], q.f[SER_OUT]};
          d.out[SER_CLK] = 1'b0;
          d.out[SER_IN] = q.sh[6];
          d.bitCnt = q.bitCnt + 3'h1;
          d.st = SERLO;
          if (q.bitCnt == 3'h7)
          begin
            d.st = HOLD;
            if (q.rd)
            begin
              d.rdByte = d.sh;
            end
          end
        end
      end
      HOLD:
      begin
        if (phaseEnd)
        begin
          d.cnt = PHASE_CYC - 5'h1;
          d.st = GAP;
          d.csN = 1'b1;
          d.wrN = 1'b1;
          d.out = BUS_NONE;
          d.oe = par ? BUS_NONE : SER_HOST_OE;
        end
      end
      GAP:
      begin
        if (phaseEnd)
        begin
          d.st = IDLE;
        end
      end
    endcase
  end

  // single state register, synchronous reset
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      q <= HOST_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  // apb answers in the first access cycle; orders while busy are refused
  assign pready = 1'b1;
  assign pslverr = access & (~mapped | (pwrite & busy &
    (paddr == REG_CMD || paddr == REG_CTRL)));
  assign prdata = q.prdata;
  // pin outputs come from the state
  assign bus.cpuSel = q.ctrl[CTRL_CPU];
  assign bus.busSel = q.ctrl[CTRL_BUS];
  assign bus.moduleResetN = q.ctrl[CTRL_MRST];
  assign bus.panelSupplyOn = q.ctrl[CTRL_HV];
  assign bus.dcSel = q.dc;
  assign bus.csN = q.csN;
  assign bus.wrN = q.wrN;
  assign bus.rdN = q.rdN;
  assign bus.hostOut = q.out;
  assign bus.hostOe = q.oe;

endmodule : oledh_host

//--- dv/oledh_chk.sv
// Purpose: pin checks between the host end and the module end
// Assumes: one clock; the module filters every pin for about four clocks
// Notes: mode dependent checks wait until the mode pins have settled
`timescale 1ns/1ns
module oledh_chk
  import oledh_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // host driven pins
  input wire logic cpuSel,
  input wire logic busSel,
  input wire logic csN,
  input wire logic moduleResetN,
  input wire logic wrN,
  input wire logic rdN,
  input wire logic panelSupplyOn,
  input wire logic [7:0] hostOut,
  // module driven pins
  input wire logic [7:0] devOe,
  input wire logic devBusy,
  input wire logic panelVcc
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // host side framing; the filter needs long phases
  sel_hold_a: assert property ($fell(csN) |-> !csN[*8])
    else $error("select released early");
  strobe_sel_a: assert property (
    (!cpuSel)[*4] ##0 !(wrN && rdN) |-> !csN)
    else $error("strobe without select");
  enable_sel_a: assert property (cpuSel[*4] ##0 rdN |-> !csN)
    else $error("enable without select");
  strobe_pair_a: assert property ((!cpuSel)[*4] |-> wrN || rdN)
    else $error("both strobes low");
  ser_clk_a: assert property (
    (!busSel)[*4] ##0 $rose(hostOut[SER_CLK]) |-> !csN)
    else $error("serial clock outside frame");

  // module side drive, judged after the filter delay
  desel_quiet_a: assert property (csN[*8] |-> devOe == BUS_NONE)
    else $error("bus driven while deselected");
  ser_drive_a: assert property (
    (!busSel)[*4] |-> (devOe & ~SER_DEV_OE) == BUS_NONE)
    else $error("serial drive on wrong bit");
  rd_drive_a: assert property (
    (busSel && !cpuSel && !rdN)[*8] |-> devOe == BUS_ALL)
    else $error("read strobe not answered");
  e_low_quiet_a: assert property (
    (busSel && cpuSel && !rdN)[*8] |-> devOe == BUS_NONE)
    else $error("drive with enable low");
  flush_busy_a: assert property ((!moduleResetN)[*8] |-> !devBusy)
    else $error("buffer kept in module reset");
  supply_a: assert property (
    $stable(panelSupplyOn)[*8] |-> panelVcc == panelSupplyOn)
    else $error("panel supply wrong");

  // main traffic seen at least once
  par_read_c: cover property (busSel && !cpuSel && !rdN && !csN);
  e_read_c: cover property (busSel && cpuSel && rdN && wrN && !csN);
  ser_c: cover property (!busSel && $rose(hostOut[SER_CLK]));
  full_c: cover property ($rose(devBusy));
endmodule : oledh_chk

//--- dv/tb.sv
// Purpose: drives the host end over apb and watches the module end
// Assumes: both ends on one 100 ns clock
// Notes: every bus style is run; expected bytes are queued by the bench
`timescale 1ns/1ns
module tb
  import oledh_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rxValid, rxIsData, initActive, panelHvOn;
  logic rxReady = 1'b1;
  logic [7:0] rxData;
  logic [7:0] txByte = 8'h00;
  logic [31:0] rdat;
  logic rerr;
  logic [8:0] expQ[$];
  logic [8:0] gotQ[$];
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;

  oledh_if bus ();
  oledh_host i_oledh_host (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus));
  oledh_dev i_oledh_dev (.clk(clk), .rst_b(rst_b), .bus(bus),
    .rxValid(rxValid), .rxReady(rxReady), .rxData(rxData),
    .rxIsData(rxIsData), .txByte(txByte), .initActive(initActive),
    .panelHvOn(panelHvOn));
  oledh_chk i_oledh_chk (.clk(clk), .rst_b(rst_b), .cpuSel(bus.cpuSel),
    .busSel(bus.busSel), .csN(bus.csN), .moduleResetN(bus.moduleResetN),
    .wrN(bus.wrN), .rdN(bus.rdN), .panelSupplyOn(bus.panelSupplyOn),
    .hostOut(bus.hostOut), .devOe(bus.devOe), .devBusy(bus.devBusy),
    .panelVcc(bus.panelVcc));

  // 10 MHz clock
  initial
  begin
    forever #50 clk = ~clk;
  end

  // collect every byte the module hands over
  always @(posedge clk)
  begin
    if (rxValid === 1'b1 && rxReady === 1'b1)
      gotQ.push_back({rxIsData, rxData});
  end

  // hang guard, far above the few thousand cycles the tests need
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      failures++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string msg);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk

  // received stream against the queued bytes, in order
  task automatic chk_rx();
    chk(gotQ.size(), expQ.size(), "byte count");
    foreach (expQ[i])
      chk(gotQ[i], expQ[i], "received byte");
    gotQ.delete();
    expQ.delete();
  endtask : chk_rx

  // one apb transfer; the answer is taken at the edge that sees pready
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    logic ok;
    int n;
    ok = 1'b0;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // the wait ends at the first edge that sees pready; it has no limit of its own
    while (ok !== 1'b1)
    begin
      @(posedge clk);
      ok = pready;
      rdat = prdata;
      rerr = pslverr;
      n++;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n, 1, "apb wait states");
  endtask : apb

  // poll status until the pin transfer is over
  task automatic idle();
    int n;
    n = 0;
    rdat = 32'h1;
    while (rdat[ST_BUSY] !== 1'b0 && n < 400)
    begin
      apb(1'b0, REG_STAT, 32'h0);
      n++;
    end
    chk(rdat[ST_BUSY], 1'b0, "host stuck busy");
  endtask : idle

  task automatic xfer(input logic rd, input logic dc, input logic [7:0] b);
    apb(1'b1, REG_CMD, {22'h0, rd, dc, b});
    chk(rerr, 1'b0, "command refused");
    if (!rd)
      expQ.push_back({dc, b});
    idle();
  endtask : xfer

  // wait covers the pin filter and the registered outputs
  task automatic ctrl(input logic [3:0] v);
    apb(1'b1, REG_CTRL, {28'h0, v});
    repeat (12) @(posedge clk);
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rdat[3:0], v, "control readback");
    chk(initActive, !v[CTRL_MRST], "init state");
    chk(panelHvOn, v[CTRL_HV], "panel high voltage");
    chk(bus.panelVcc, v[CTRL_HV], "panel supply out");
  endtask : ctrl

  initial
  begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    chk(initActive, 1'b1, "init after reset");
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rdat[3:0], CTRL_RESET, "control reset value");
    apb(1'b0, 12'h00c, 32'h0);
    chk({rerr, rdat[30:0]}, 32'h80000000, "unmapped read");
    apb(1'b1, 12'h010, 32'hff);
    chk(rerr, 1'b1, "unmapped write");
    // serial and parallel, 80xx and 68xx
    for (int m = 0; m < 4; m++)
    begin
      ctrl({2'b11, m[1:0]});
      txByte <= 8'h4b ^ 8'(m);
      xfer(1'b0, 1'b0, 8'h83 + 8'(m));
      xfer(1'b0, 1'b1, 8'h2d ^ 8'(m));
      xfer(1'b1, 1'b0, 8'h00);
      apb(1'b0, REG_STAT, 32'h0);
      chk(rdat[15:8], 8'h4b ^ 8'(m), "read byte");
      chk_rx();
    end
    // receiver stalls: two bytes fill the buffer, the third waits
    rxReady <= 1'b0;
    xfer(1'b0, 1'b1, 8'h11);
    xfer(1'b0, 1'b1, 8'h22);
    repeat (8) @(posedge clk);
    apb(1'b0, REG_STAT, 32'h0);
    chk(rdat[ST_DEVBUSY], 1'b1, "buffer not full");
    apb(1'b1, REG_CMD, 32'h133);
    chk(rerr, 1'b0, "third byte refused");
    expQ.push_back(9'h133);
    apb(1'b1, REG_CMD, 32'h144);
    chk(rerr, 1'b1, "command while busy");
    repeat (40) @(posedge clk);
    chk(gotQ.size(), 0, "byte during stall");
    rxReady <= 1'b1;
    idle();
    chk_rx();
    // module reset held: the byte must be ignored
    ctrl(4'h6);
    xfer(1'b0, 1'b1, 8'h55);
    expQ.delete();
    chk_rx();
    ctrl(4'h8);
    print_verdict();
  end
endmodule : tb
